// ### core/rto_pkg.sv
// Behaviour
// - Loop-open bit opens synthesizer loop, resets 0
// - Pump force select applies 4-bit force current
// - Oscillator array force select applies value, default 16
// - Manual calibration enable gives software-stepped calibration
// - Calibration current force select applies value, default 6
// - Manual mode: falling select samples calibration comparator
// - Pump disable, force up, force down bits
// - Mixer DC force sets I and Q signs
// - Probe routed: interface field drives powerdown, mode
// - Probe unrouted: powerdown 1, mode top bit 1
// - Frequency comparator output gated by enable bit
// - Dither enable bit, reset 1
// - Sample dump drives lock, data, clock pins
// - Chop, shaping, rotation disable bits, reset 0
// - Rotation code selects converter position sequence
// - Gain override; first coupler 0 or -12 dB
// - Second coupler code selects four attenuations
// - Three stage gain override fields, reset 0
// - Calibration DAC override only while loop open
package rto_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DAC_PUMP  = 8'h21;
  localparam logic [7:0] IDX_LOOP      = 8'h22;
  localparam logic [7:0] IDX_CAL_MAN   = 8'h23;
  localparam logic [7:0] IDX_PUMP_MIX  = 8'h24;
  localparam logic [7:0] IDX_CONV      = 8'h25;
  localparam logic [7:0] IDX_COUPLER   = 8'h26;
  localparam logic [7:0] IDX_STAGE     = 8'h27;
  localparam logic [7:0] IDX_STATUS    = 8'h28;

  // Reset values
  localparam logic [7:0] RST_DAC_PUMP  = 8'h4D;
  localparam logic [7:0] RST_LOOP      = 8'h10;
  localparam logic [7:0] RST_CAL_MAN   = 8'h06;
  localparam logic [7:0] RST_PUMP_MIX  = 8'h00;
  localparam logic [7:0] RST_CONV      = 8'h40;
  localparam logic [7:0] RST_COUPLER   = 8'h00;
  localparam logic [7:0] RST_STAGE     = 8'h00;

  // Field positions
  localparam int B_LOOP_OPEN     = 7;
  localparam int B_PUMP_SEL      = 6;
  localparam int B_OSC_SEL       = 5;
  localparam int B_MAN_EN        = 7;
  localparam int B_CAL_SEL       = 6;
  localparam int B_PUMP_OFF      = 7;
  localparam int B_PUMP_UP       = 6;
  localparam int B_PUMP_DN       = 5;
  localparam int B_MIX_LVL       = 3;
  localparam int B_MIX_EN        = 2;
  localparam int B_PRB_FILT      = 1;
  localparam int B_PRB_CONV      = 0;
  localparam int B_FCMP_EN       = 7;
  localparam int B_DITHER        = 6;
  localparam int B_DUMP          = 5;
  localparam int B_CHOP_OFF      = 4;
  localparam int B_SHAPE_OFF     = 3;
  localparam int B_CMROT_OFF     = 2;
  localparam int B_GAIN_EN       = 3;
  localparam int B_CPL1          = 2;
  localparam int B_STG1          = 4;
  localparam int B_STG2          = 2;

  // Rotation sequence codes
  typedef enum logic [1:0] {
    RTO_ROT_LINEAR = 2'b00,
    RTO_ROT_GRAY   = 2'b01,
    RTO_ROT_HOLD   = 2'b10,
    RTO_ROT_ALT    = 2'b11
  } rto_rot_e;

endpackage : rto_pkg

// ### core/rto_override_regs.sv
`timescale 1ns/1ps
module rto_override_regs
  import rto_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  // Avalon-MM slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Calibrated and automatic values from the analog control logic
  input  wire logic [3:0]  PUMP_CURRENT_CALIB,
  input  wire logic [4:0]  OSC_ARRAY_CALIB,
  input  wire logic [5:0]  OSC_CAL_CURRENT_CALIB,
  input  wire logic [3:0]  CAL_DAC_CALIB,
  input  wire logic        CAL_COMPARATOR_OUT,
  input  wire logic [3:0]  INTERFACE_CTRL,
  input  wire logic        FREQ_COMP_RAW,
  input  wire logic        CONV_SAMPLE_A,
  input  wire logic        CONV_SAMPLE_B,
  input  wire logic        CONV_SAMPLE_CLK,
  input  wire logic        LOCK_NORMAL,
  input  wire logic        DATA_INOUT_NORMAL,
  input  wire logic        DATA_INOUT_NORMAL_OE,
  input  wire logic        DATA_CLOCK_NORMAL,
  input  wire logic        ROTATE_STEP,
  input  wire logic        AUTO_COUPLER1,
  input  wire logic [1:0]  AUTO_COUPLER2,
  input  wire logic [1:0]  AUTO_STAGE1,
  input  wire logic [1:0]  AUTO_STAGE2,
  input  wire logic [1:0]  AUTO_STAGE3,
  // Applied controls
  output logic             LOOP_OPEN,
  output logic      [3:0]  PUMP_CURRENT,
  output logic      [4:0]  OSC_ARRAY_SETTING,
  output logic      [5:0]  OSC_CAL_CURRENT_SETTING,
  output logic      [3:0]  CAL_DAC,
  output logic             MANUAL_OSC_CAL_EN,
  output logic             MANUAL_CAL_STROBE,
  output logic             CAL_SAMPLE_PULSE,
  output logic             CAL_COMP_SAMPLE,
  output logic             PUMP_NORMAL_OFF,
  output logic             PUMP_FORCE_UP,
  output logic             PUMP_FORCE_DOWN,
  output logic             MIXER_DC_FORCE_EN,
  output logic             MIXER_I_POS,
  output logic             MIXER_Q_POS,
  output logic             PROBE_TO_FILTER_EN,
  output logic             PROBE_TO_CONVERTER_EN,
  output logic             ANALOG_PROBE_POWERDOWN,
  output logic      [2:0]  PROBE_MODE,
  output logic             FREQ_COMP_OUT,
  output logic             SIGMA_DELTA_DITHER_EN,
  output logic             LOCK_PIN,
  output logic             DATA_INOUT_PIN,
  output logic             DATA_INOUT_OE,
  output logic             DATA_CLOCK_PIN,
  output logic             INTEGRATOR_CHOP_OFF,
  output logic             SHAPING_OFF,
  output logic             COMMON_MODE_ROTATION_OFF,
  output logic      [1:0]  CONV_INPUT_POS,
  output logic             FIRST_COUPLER,
  output logic      [1:0]  SECOND_COUPLER,
  output logic      [1:0]  STAGE1_GAIN,
  output logic      [1:0]  STAGE2_GAIN,
  output logic      [1:0]  STAGE3_GAIN
);

  // Stored register images
  logic [7:0] r_dac_pump;     // Calibration DAC and pump force values
  logic [7:0] r_loop;         // synth_loop_override_ctrl
  logic [7:0] r_cal_man;      // osc_cal_manual_ctrl
  logic [7:0] r_pump_mix;     // pump_mixer_probe_ctrl
  logic [7:0] r_conv;         // converter_modulator_ctrl
  logic [3:0] r_coupler;      // gain_coupler_override, low nibble only
  logic [5:0] r_stage;        // gain_stage_override, low six bits only
  logic       strobe_prev;    // Previous strobe level for edge detect
  logic [7:0] next_rdata;     // Read mux output
  logic       wr_go;          // Write completes this edge
  logic       req;            // Any request present
  logic       probe_routed;   // Probe connected somewhere
  logic       gain_on;        // Gain override active
  logic       strobe_fall;    // Strobe falling edge in manual mode

  function automatic logic [7:0] word_addr(input logic [7:0] idx);
    word_addr = {idx[5:0], 2'b00};
  endfunction : word_addr

  // Next converter position for each rotation code
  function automatic logic [1:0] next_pos(input logic [1:0] code, input logic [1:0] pos);
    case (code)
      RTO_ROT_LINEAR: next_pos = pos + 2'b01;
      RTO_ROT_GRAY:   next_pos = {~pos[0], pos[1]}; // 00, 10, 11, 01 and round
      RTO_ROT_HOLD:   next_pos = 2'b00;
      RTO_ROT_ALT:    next_pos = (pos == 2'b00) ? 2'b10 : 2'b00;
      default:        next_pos = 2'b00;
    endcase
  endfunction : next_pos

  assign req          = AVS_READ | AVS_WRITE;
  assign wr_go        = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
  assign probe_routed = r_pump_mix[B_PRB_FILT] | r_pump_mix[B_PRB_CONV];
  assign gain_on      = r_coupler[B_GAIN_EN];
  assign strobe_fall  = r_cal_man[B_MAN_EN] & strobe_prev & ~r_cal_man[B_CAL_SEL];

  // Bus handshake: one wait cycle, then the transfer completes
  // fixed latency
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
      AVS_WAITREQUEST <= 1'b1;
    else if (req && AVS_WAITREQUEST)
      AVS_WAITREQUEST <= 1'b0;
    else
      AVS_WAITREQUEST <= 1'b1;
  end

  // Read mux; unmapped addresses read as zero
  always_comb
  begin
    next_rdata = 8'h00;
    case (AVS_ADDRESS)
      word_addr(IDX_DAC_PUMP): next_rdata = r_dac_pump;
      word_addr(IDX_LOOP):     next_rdata = r_loop;
      word_addr(IDX_CAL_MAN):  next_rdata = r_cal_man;
      word_addr(IDX_PUMP_MIX): next_rdata = r_pump_mix;
      word_addr(IDX_CONV):     next_rdata = r_conv;
      word_addr(IDX_COUPLER):  next_rdata = {4'h0, r_coupler};
      word_addr(IDX_STAGE):    next_rdata = {2'b00, r_stage};
      word_addr(IDX_STATUS):   next_rdata = {4'h0, LOOP_OPEN, CONV_INPUT_POS, CAL_COMP_SAMPLE};
      default:                 next_rdata = 8'h00;
    endcase
  end

  // Read data is loaded during the wait cycle so it stands at completion
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
      AVS_READDATA <= 32'h0000_0000;
    else if (AVS_READ && AVS_WAITREQUEST)
      AVS_READDATA <= {24'h00_0000, next_rdata};
  end

  // Register writes; only byte lane 0 carries data
  // reset defaults
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      r_dac_pump <= RST_DAC_PUMP;
      r_loop     <= RST_LOOP;
      r_cal_man  <= RST_CAL_MAN;
      r_pump_mix <= RST_PUMP_MIX;
      r_conv     <= RST_CONV;
      r_coupler  <= RST_COUPLER[3:0];
      r_stage    <= RST_STAGE[5:0];
    end
    else if (wr_go)
    begin
      case (AVS_ADDRESS)
        word_addr(IDX_DAC_PUMP): r_dac_pump <= AVS_WRITEDATA[7:0];
        word_addr(IDX_LOOP):     r_loop     <= AVS_WRITEDATA[7:0];
        word_addr(IDX_CAL_MAN):  r_cal_man  <= AVS_WRITEDATA[7:0];
        word_addr(IDX_PUMP_MIX): r_pump_mix <= AVS_WRITEDATA[7:0];
        word_addr(IDX_CONV):     r_conv     <= AVS_WRITEDATA[7:0];
        word_addr(IDX_COUPLER):  r_coupler  <= AVS_WRITEDATA[3:0];
        word_addr(IDX_STAGE):    r_stage    <= AVS_WRITEDATA[5:0];
        default:                 r_dac_pump <= r_dac_pump;
      endcase
    end
  end

  // Synthesizer loop and forced currents
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      LOOP_OPEN               <= 1'b0;
      PUMP_CURRENT            <= 4'h0;
      OSC_ARRAY_SETTING       <= 5'h00;
      OSC_CAL_CURRENT_SETTING <= 6'h00;
      CAL_DAC                 <= 4'h0;
    end
    else
    begin
      LOOP_OPEN <= r_loop[B_LOOP_OPEN];
      PUMP_CURRENT <= r_loop[B_PUMP_SEL] ? r_dac_pump[3:0] : PUMP_CURRENT_CALIB;
      OSC_ARRAY_SETTING <= r_loop[B_OSC_SEL] ? r_loop[4:0] : OSC_ARRAY_CALIB;
      // current force; manual stepping also uses the force value
      OSC_CAL_CURRENT_SETTING <= (r_cal_man[B_CAL_SEL] || r_cal_man[B_MAN_EN])
                                 ? r_cal_man[5:0] : OSC_CAL_CURRENT_CALIB;
      CAL_DAC <= r_loop[B_LOOP_OPEN] ? r_dac_pump[7:4] : CAL_DAC_CALIB;
    end
  end

  // Manual calibration: the select bit becomes a software strobe
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      strobe_prev       <= 1'b0;
      MANUAL_OSC_CAL_EN <= 1'b0;
      MANUAL_CAL_STROBE <= 1'b0;
      CAL_SAMPLE_PULSE  <= 1'b0;
      CAL_COMP_SAMPLE   <= 1'b0;
    end
    else
    begin
      strobe_prev <= r_cal_man[B_CAL_SEL];
      MANUAL_OSC_CAL_EN <= r_cal_man[B_MAN_EN];
      MANUAL_CAL_STROBE <= r_cal_man[B_MAN_EN] & r_cal_man[B_CAL_SEL];
      CAL_SAMPLE_PULSE <= strobe_fall;
      if (strobe_fall)
        CAL_COMP_SAMPLE <= CAL_COMPARATOR_OUT;
    end
  end

  // Charge pump and mixer DC forcing
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      PUMP_NORMAL_OFF   <= 1'b0;
      PUMP_FORCE_UP     <= 1'b0;
      PUMP_FORCE_DOWN   <= 1'b0;
      MIXER_DC_FORCE_EN <= 1'b0;
      MIXER_I_POS       <= 1'b0;
      MIXER_Q_POS       <= 1'b0;
    end
    else
    begin
      PUMP_NORMAL_OFF <= r_pump_mix[B_PUMP_OFF];
      PUMP_FORCE_UP   <= r_pump_mix[B_PUMP_UP];
      PUMP_FORCE_DOWN <= r_pump_mix[B_PUMP_DN];
      // mixer levels; held low when not forced so nothing stray leaks out
      MIXER_DC_FORCE_EN <= r_pump_mix[B_MIX_EN];
      MIXER_I_POS <= r_pump_mix[B_MIX_EN] & r_pump_mix[B_MIX_LVL+1];
      MIXER_Q_POS <= r_pump_mix[B_MIX_EN] & r_pump_mix[B_MIX_LVL];
    end
  end

  // Analog probe routing
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      PROBE_TO_FILTER_EN     <= 1'b0;
      PROBE_TO_CONVERTER_EN  <= 1'b0;
      ANALOG_PROBE_POWERDOWN <= 1'b1;
      PROBE_MODE             <= 3'b100;
    end
    else
    begin
      PROBE_TO_FILTER_EN    <= r_pump_mix[B_PRB_FILT];
      PROBE_TO_CONVERTER_EN <= r_pump_mix[B_PRB_CONV];
      ANALOG_PROBE_POWERDOWN <= probe_routed ? INTERFACE_CTRL[3] : 1'b1;
      PROBE_MODE             <= probe_routed ? INTERFACE_CTRL[2:0] : {1'b1, INTERFACE_CTRL[1:0]};
    end
  end

  // Modulator, converter controls and pin sharing for sample dump
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      FREQ_COMP_OUT            <= 1'b0;
      SIGMA_DELTA_DITHER_EN    <= 1'b1;
      LOCK_PIN                 <= 1'b0;
      DATA_INOUT_PIN           <= 1'b0;
      DATA_INOUT_OE            <= 1'b0;
      DATA_CLOCK_PIN           <= 1'b0;
      INTEGRATOR_CHOP_OFF      <= 1'b0;
      SHAPING_OFF              <= 1'b0;
      COMMON_MODE_ROTATION_OFF <= 1'b0;
    end
    else
    begin
      FREQ_COMP_OUT <= r_conv[B_FCMP_EN] & FREQ_COMP_RAW;
      SIGMA_DELTA_DITHER_EN <= r_conv[B_DITHER];
      // sample dump; pins are one cycle behind the sources
      LOCK_PIN       <= r_conv[B_DUMP] ? CONV_SAMPLE_A : LOCK_NORMAL;
      DATA_INOUT_PIN <= r_conv[B_DUMP] ? CONV_SAMPLE_B : DATA_INOUT_NORMAL;
      DATA_INOUT_OE  <= r_conv[B_DUMP] | DATA_INOUT_NORMAL_OE;
      DATA_CLOCK_PIN <= r_conv[B_DUMP] ? CONV_SAMPLE_CLK : DATA_CLOCK_NORMAL;
      INTEGRATOR_CHOP_OFF      <= r_conv[B_CHOP_OFF];
      SHAPING_OFF              <= r_conv[B_SHAPE_OFF];
      COMMON_MODE_ROTATION_OFF <= r_conv[B_CMROT_OFF];
    end
  end

  // Converter input rotation, stepped by the converter rate enable
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
      CONV_INPUT_POS <= 2'b00;
    else if (ROTATE_STEP)
      CONV_INPUT_POS <= next_pos(r_conv[1:0], CONV_INPUT_POS);
  end

  // Gain stage overrides
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      FIRST_COUPLER  <= 1'b0;
      SECOND_COUPLER <= 2'b00;
      STAGE1_GAIN    <= 2'b00;
      STAGE2_GAIN    <= 2'b00;
      STAGE3_GAIN    <= 2'b00;
    end
    else
    begin
      FIRST_COUPLER  <= gain_on ? r_coupler[B_CPL1] : AUTO_COUPLER1;
      SECOND_COUPLER <= gain_on ? r_coupler[1:0] : AUTO_COUPLER2;
      STAGE1_GAIN <= gain_on ? r_stage[B_STG1+1:B_STG1] : AUTO_STAGE1;
      STAGE2_GAIN <= gain_on ? r_stage[B_STG2+1:B_STG2] : AUTO_STAGE2;
      STAGE3_GAIN <= gain_on ? r_stage[1:0] : AUTO_STAGE3;
    end
  end

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  property p_loop_open;
    r_loop[B_LOOP_OPEN] |=> LOOP_OPEN;
  endproperty
  a_loop_open: assert property (p_loop_open) else $error("loop not opened");

  property p_pump_force;
    r_loop[B_PUMP_SEL] |=> PUMP_CURRENT == $past(r_dac_pump[3:0]);
  endproperty
  a_pump_force: assert property (p_pump_force) else $error("pump force wrong");

  property p_osc_calib;
    !r_loop[B_OSC_SEL] |=> OSC_ARRAY_SETTING == $past(OSC_ARRAY_CALIB);
  endproperty
  a_osc_calib: assert property (p_osc_calib) else $error("array not calibrated");

  property p_cal_sample;
    (r_cal_man[B_MAN_EN] && $fell(r_cal_man[B_CAL_SEL]))
      |=> CAL_SAMPLE_PULSE && CAL_COMP_SAMPLE == $past(CAL_COMPARATOR_OUT);
  endproperty
  a_cal_sample: assert property (p_cal_sample) else $error("comparator not sampled");

  property p_probe_park;
    !probe_routed |=> ANALOG_PROBE_POWERDOWN && PROBE_MODE[2];
  endproperty
  a_probe_park: assert property (p_probe_park) else $error("probe not parked");

  property p_dump;
    r_conv[B_DUMP] |=> LOCK_PIN == $past(CONV_SAMPLE_A) && DATA_INOUT_OE;
  endproperty
  a_dump: assert property (p_dump) else $error("dump pins wrong");

  property p_rot_hold;
    (r_conv[1:0] == RTO_ROT_HOLD && ROTATE_STEP) |=> CONV_INPUT_POS == 2'b00;
  endproperty
  a_rot_hold: assert property (p_rot_hold) else $error("rotation not held");

  property p_gain;
    gain_on |=> SECOND_COUPLER == $past(r_coupler[1:0]) && STAGE3_GAIN == $past(r_stage[1:0]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain override wrong");

  property p_dac_gate;
    !r_loop[B_LOOP_OPEN] |=> CAL_DAC == $past(CAL_DAC_CALIB);
  endproperty
  a_dac_gate: assert property (p_dac_gate) else $error("DAC override leaked");

  property p_bus_answer;
    (req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  c_manual_sample: cover property (r_cal_man[B_MAN_EN] && strobe_fall);
  c_dump_on:       cover property (r_conv[B_DUMP] && ROTATE_STEP);
  c_gray_rot:      cover property (r_conv[1:0] == RTO_ROT_GRAY && CONV_INPUT_POS == 2'b01);
endmodule : rto_override_regs

// ### test/test_rf_test_override_regs.sv
`timescale 1ns/1ps
module test_rf_test_override_regs;
  import rto_pkg::*;
  // Bench signals share the design's port names so the instance can use named shorthand
  logic        CLK_SYS, RST_B, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, CAL_COMPARATOR_OUT;
  logic        FREQ_COMP_RAW, CONV_SAMPLE_A, CONV_SAMPLE_B, CONV_SAMPLE_CLK, LOCK_NORMAL;
  logic        DATA_INOUT_NORMAL, DATA_INOUT_NORMAL_OE, DATA_CLOCK_NORMAL;
  logic        ROTATE_STEP, AUTO_COUPLER1;
  logic        LOOP_OPEN, MANUAL_OSC_CAL_EN, MANUAL_CAL_STROBE, CAL_SAMPLE_PULSE;
  logic        CAL_COMP_SAMPLE, PUMP_NORMAL_OFF, PUMP_FORCE_UP, PUMP_FORCE_DOWN;
  logic        MIXER_DC_FORCE_EN, MIXER_I_POS, MIXER_Q_POS, PROBE_TO_FILTER_EN;
  logic        PROBE_TO_CONVERTER_EN, ANALOG_PROBE_POWERDOWN, FREQ_COMP_OUT;
  logic        SIGMA_DELTA_DITHER_EN, LOCK_PIN, DATA_INOUT_PIN, DATA_INOUT_OE, DATA_CLOCK_PIN;
  logic        INTEGRATOR_CHOP_OFF, SHAPING_OFF, COMMON_MODE_ROTATION_OFF, FIRST_COUPLER;
  logic [7:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic [3:0]  AVS_BYTEENABLE, PUMP_CURRENT_CALIB, CAL_DAC_CALIB, INTERFACE_CTRL;
  logic [3:0]  PUMP_CURRENT, CAL_DAC;
  logic [4:0]  OSC_ARRAY_CALIB, OSC_ARRAY_SETTING;
  logic [5:0]  OSC_CAL_CURRENT_CALIB, OSC_CAL_CURRENT_SETTING;
  logic [2:0]  PROBE_MODE;
  logic [1:0]  AUTO_COUPLER2, AUTO_STAGE1, AUTO_STAGE2, AUTO_STAGE3, CONV_INPUT_POS;
  logic [1:0]  SECOND_COUPLER, STAGE1_GAIN, STAGE2_GAIN, STAGE3_GAIN;
  // Reference model state: register images, converter position, verdict counters
  logic [7:0]  m [0:6];
  int          pos, failures, checks, cyc;
  logic        v;

  rto_override_regs u_rto_override_regs (
    .CLK_SYS, .RST_B, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE,
    .AVS_READDATA, .AVS_WAITREQUEST, .PUMP_CURRENT_CALIB, .OSC_ARRAY_CALIB,
    .OSC_CAL_CURRENT_CALIB, .CAL_DAC_CALIB, .CAL_COMPARATOR_OUT, .INTERFACE_CTRL,
    .FREQ_COMP_RAW, .CONV_SAMPLE_A, .CONV_SAMPLE_B, .CONV_SAMPLE_CLK, .LOCK_NORMAL,
    .DATA_INOUT_NORMAL, .DATA_INOUT_NORMAL_OE, .DATA_CLOCK_NORMAL, .ROTATE_STEP,
    .AUTO_COUPLER1, .AUTO_COUPLER2,
    .AUTO_STAGE1, .AUTO_STAGE2, .AUTO_STAGE3, .LOOP_OPEN, .PUMP_CURRENT, .OSC_ARRAY_SETTING,
    .OSC_CAL_CURRENT_SETTING, .CAL_DAC, .MANUAL_OSC_CAL_EN, .MANUAL_CAL_STROBE,
    .CAL_SAMPLE_PULSE, .CAL_COMP_SAMPLE, .PUMP_NORMAL_OFF, .PUMP_FORCE_UP, .PUMP_FORCE_DOWN,
    .MIXER_DC_FORCE_EN, .MIXER_I_POS, .MIXER_Q_POS, .PROBE_TO_FILTER_EN,
    .PROBE_TO_CONVERTER_EN, .ANALOG_PROBE_POWERDOWN, .PROBE_MODE, .FREQ_COMP_OUT,
    .SIGMA_DELTA_DITHER_EN, .LOCK_PIN, .DATA_INOUT_PIN, .DATA_INOUT_OE, .DATA_CLOCK_PIN,
    .INTEGRATOR_CHOP_OFF, .SHAPING_OFF, .COMMON_MODE_ROTATION_OFF, .CONV_INPUT_POS,
    .FIRST_COUPLER, .SECOND_COUPLER, .STAGE1_GAIN, .STAGE2_GAIN, .STAGE3_GAIN
  );

  // 50 MHz clock
  always #10 CLK_SYS = ~CLK_SYS;

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge CLK_SYS)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      failures++;
      final_report();
    end
  end

  task automatic final_report();
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // One comparison, four-state exact
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // Avalon master: hold the request until waitrequest is sampled low
  task automatic avs(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    AVS_ADDRESS    <= adr;
    AVS_WRITEDATA  <= wd;
    AVS_BYTEENABLE <= be;
    AVS_READ       <= !wr;
    AVS_WRITE      <= wr;
    do
    begin
      @(posedge CLK_SYS);
      n++;
    end
    while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    cmp(32'(n), 32'd2);
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : avs

  // Register write by index; the model follows only when the low byte lane is enabled
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
    logic [31:0] x;
    avs(1'b1, {idx[5:0], 2'b00}, {24'($urandom()), d}, be, x);
    if (be[0] && idx >= 8'h21 && idx <= 8'h27)
      m[idx - 8'h21] = d;
  endtask : reg_wr

  // Register read by index; unmapped places read zero
  task automatic reg_rd(input logic [7:0] idx);
    logic [31:0] x;
    avs(1'b0, {idx[5:0], 2'b00}, 32'h0000_0000, 4'hF, x);
    cmp(x, (idx >= 8'h21 && idx <= 8'h27) ? {24'h00_0000, m[idx - 8'h21]}
                                          : 32'h0000_0000);
  endtask : reg_rd

  // Random levels on the analog-side inputs; comparator stays put for the status read
  task automatic rand_in();
    @(posedge CLK_SYS);
    {PUMP_CURRENT_CALIB, OSC_ARRAY_CALIB, OSC_CAL_CURRENT_CALIB, CAL_DAC_CALIB,
     INTERFACE_CTRL, FREQ_COMP_RAW, CONV_SAMPLE_A, CONV_SAMPLE_B, CONV_SAMPLE_CLK,
     LOCK_NORMAL, DATA_INOUT_NORMAL, DATA_INOUT_NORMAL_OE, DATA_CLOCK_NORMAL} <= 31'($urandom());
    {AUTO_COUPLER1, AUTO_COUPLER2, AUTO_STAGE1, AUTO_STAGE2, AUTO_STAGE3} <= 9'($urandom());
  endtask : rand_in

  // Let outputs settle two edges, then compare every applied control except CAL_SAMPLE_PULSE and CAL_COMP_SAMPLE with the model
  task automatic chk_out();
    logic [7:0] r1, r2, r3, r4, r5, r6, r7;
    repeat (2) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    {r1, r2, r3, r4, r5, r6, r7} = {m[0], m[1], m[2], m[3], m[4], m[5], m[6]};
    cmp({LOOP_OPEN, PUMP_CURRENT, OSC_ARRAY_SETTING, OSC_CAL_CURRENT_SETTING, CAL_DAC,
         MANUAL_OSC_CAL_EN, MANUAL_CAL_STROBE},
        {r2[7], r2[6] ? r1[3:0] : PUMP_CURRENT_CALIB, r2[5] ? r2[4:0] : OSC_ARRAY_CALIB,
         (r3[7] | r3[6]) ? r3[5:0] : OSC_CAL_CURRENT_CALIB,
         r2[7] ? r1[7:4] : CAL_DAC_CALIB, r3[7], r3[7] & r3[6]});
    cmp({PUMP_NORMAL_OFF, PUMP_FORCE_UP, PUMP_FORCE_DOWN, MIXER_DC_FORCE_EN, MIXER_I_POS,
         MIXER_Q_POS, PROBE_TO_FILTER_EN, PROBE_TO_CONVERTER_EN},
        {r4[7:5], r4[2], r4[2] & r4[4], r4[2] & r4[3], r4[1:0]});
    cmp({ANALOG_PROBE_POWERDOWN, PROBE_MODE},
        (|r4[1:0]) ? INTERFACE_CTRL : {2'b11, INTERFACE_CTRL[1:0]});
    cmp({FREQ_COMP_OUT, SIGMA_DELTA_DITHER_EN, LOCK_PIN, DATA_INOUT_PIN, DATA_INOUT_OE,
         DATA_CLOCK_PIN, INTEGRATOR_CHOP_OFF, SHAPING_OFF, COMMON_MODE_ROTATION_OFF,
         CONV_INPUT_POS},
        {r5[7] & FREQ_COMP_RAW, r5[6],
         r5[5] ? {CONV_SAMPLE_A, CONV_SAMPLE_B, 1'b1, CONV_SAMPLE_CLK}
               : {LOCK_NORMAL, DATA_INOUT_NORMAL, DATA_INOUT_NORMAL_OE, DATA_CLOCK_NORMAL},
         r5[4:2], 2'(pos)});
    cmp({FIRST_COUPLER, SECOND_COUPLER, STAGE1_GAIN, STAGE2_GAIN, STAGE3_GAIN},
        r6[3] ? {r6[2:0], r7[5:0]}
              : {AUTO_COUPLER1, AUTO_COUPLER2, AUTO_STAGE1, AUTO_STAGE2, AUTO_STAGE3});
  endtask : chk_out

  // Next converter position for a rotation code
  function automatic int nxt(input int c, input int p);
    case (c)
      0: return (p + 1) % 4;
      1: return (p == 0) ? 2 : (p == 2) ? 3 : (p == 3) ? 1 : 0;
      2: return 0;
      default: return (p == 0) ? 2 : 0;
    endcase
  endfunction : nxt

  initial
  begin
    void'($urandom(32'he0a4));
    {CLK_SYS, RST_B, AVS_READ, AVS_WRITE, ROTATE_STEP, CAL_COMPARATOR_OUT} = '0;
    {AVS_ADDRESS, AVS_WRITEDATA, AVS_BYTEENABLE} = '0;
    {PUMP_CURRENT_CALIB, OSC_ARRAY_CALIB, OSC_CAL_CURRENT_CALIB, CAL_DAC_CALIB, INTERFACE_CTRL,
     FREQ_COMP_RAW, CONV_SAMPLE_A, CONV_SAMPLE_B, CONV_SAMPLE_CLK, LOCK_NORMAL,
     DATA_INOUT_NORMAL, DATA_INOUT_NORMAL_OE, DATA_CLOCK_NORMAL, AUTO_COUPLER1, AUTO_COUPLER2,
     AUTO_STAGE1, AUTO_STAGE2,
     AUTO_STAGE3} = '0;
    m = '{8'h4D, 8'h10, 8'h06, 8'h00, 8'h40, 8'h00, 8'h00};
    {pos, failures, checks, cyc} = '0;
    // Levels held while reset is asserted
    @(negedge CLK_SYS);
    cmp({AVS_WAITREQUEST, ANALOG_PROBE_POWERDOWN, PROBE_MODE, SIGMA_DELTA_DITHER_EN, LOOP_OPEN},
        7'b1_1_100_1_0);
    repeat (2) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    rand_in();
    chk_out();
    // Defaults, then unmapped places below and above the bank
    for (int i = 8'h21; i <= 8'h27; i++)
      reg_rd(8'(i));
    reg_wr(8'h20, 8'hFF, 4'hF);
    reg_rd(8'h20);
    reg_rd(8'h29);
    // Manual calibration strobe: falling select samples the comparator only in manual mode
    for (int man = 0; man < 2; man++)
    begin
      int n;
      v = 1'($urandom());
      @(posedge CLK_SYS);
      CAL_COMPARATOR_OUT <= v;
      reg_wr(8'h23, {1'(man), 7'h45}, 4'h1);
      reg_wr(8'h23, {1'(man), 7'h05}, 4'h1);
      n = 0;
      repeat (6) @(negedge CLK_SYS) n += (CAL_SAMPLE_PULSE === 1'b1);
      cmp(32'(n), 32'(man));
      if (man == 1)
        cmp(32'(CAL_COMP_SAMPLE), 32'(v));
      chk_out();
    end
    // Every rotation code, four steps each, starting from position zero
    for (int c = 0; c < 4; c++)
    begin
      reg_wr(8'h25, 8'h40 | 8'(c), 4'h1);
      repeat (4)
      begin
        @(posedge CLK_SYS);
        ROTATE_STEP <= 1'b1;
        @(posedge CLK_SYS);
        ROTATE_STEP <= 1'b0;
        pos = nxt(c, pos);
        @(negedge CLK_SYS);
        cmp(32'(CONV_INPUT_POS), 32'(pos));
      end
    end
    // Random writes with random lanes; reserved gain bits written as zero
    repeat (60)
    begin
      int idx;
      logic [7:0] d;
      idx = 8'h21 + ($urandom() % 7);
      d = 8'($urandom());
      if (idx == 8'h26) d &= 8'h0F;
      if (idx == 8'h27) d &= 8'h3F;
      rand_in();
      reg_wr(8'(idx), d, 4'($urandom()) | 4'($urandom()));
      reg_rd(8'(idx));
      chk_out();
    end
    // Status readback: loop state, position, held comparator sample
    begin
      logic [31:0] x;
      avs(1'b0, 8'hA0, 32'h0000_0000, 4'hF, x);
      cmp(x, {28'h000_0000, m[1][7], 2'(pos), v});
    end
    final_report();
  end

endmodule : test_rf_test_override_regs
